//--- logic/pwmsd_defs.svh
`ifndef PWMSD_DEFS_SVH
`define PWMSD_DEFS_SVH
// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define PWMSD_IDX_ENABLE 6'h00
`define PWMSD_IDX_POL    6'h01
`define PWMSD_IDX_CLKSEL 6'h02
`define PWMSD_IDX_PRESC  6'h03
`define PWMSD_IDX_CTL    6'h05
`define PWMSD_IDX_SCLA   6'h08
`define PWMSD_IDX_SCLB   6'h09
`define PWMSD_IDX_CNT0   6'h0c
`define PWMSD_IDX_PER0   6'h14
`define PWMSD_IDX_DTY0   6'h1c
`define PWMSD_IDX_SDN    6'h24
`define PWMSD_NUM_CH     6'h08
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PWMSD_SDN_FLAG   7
`define PWMSD_SDN_IE     6
`define PWMSD_SDN_RSTRT  5
`define PWMSD_SDN_LVL    4
`define PWMSD_SDN_PIN    2
`define PWMSD_SDN_INL    1
`define PWMSD_SDN_ENA    0
`define PWMSD_CTL_FRZ    2
`define PWMSD_PRE_A_LSB  0
`define PWMSD_PRE_B_LSB  4
`define PWMSD_SD_CH      7
// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PWMSD_PER_RST    8'h00
`define PWMSD_DTY_RST    8'hff
`define PWMSD_REG_RST    8'h00
`define PWMSD_CNT_ONE    8'h01
`define PWMSD_CNT_ZERO   8'h00
`endif

//--- logic/pwmsd_pkg.sv
package pwmsd_pkg;
  // Per-channel configuration as seen by a channel timer
  typedef struct packed {
    logic       en;
    logic       pol;
    logic [7:0] per;
    logic [7:0] dty;
  } pwmsd_chan_cfg_type;

  // Per-channel state returned to the register block
  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
    logic       wrap;
  } pwmsd_chan_stat_type;
endpackage : pwmsd_pkg

//--- logic/pwmsd_scaler.sv
`include "pwmsd_defs.svh"
module pwmsd_scaler (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       load_i,
  input  wire logic [7:0] scale_i,
  output logic            stick_o
);
  import pwmsd_pkg::*;

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       div_q;
  logic       div_d;
  logic       hit;

  // ----------------------------------------
  // Down counter and divide by two
  // ----------------------------------------
  // Zero reloads and wraps through 255, so it spans 256 ticks
  assign hit = tick_i & (cnt_q == `PWMSD_CNT_ONE);

  always_comb begin
    cnt_d = cnt_q;
    div_d = div_q;
    if (load_i) begin
      cnt_d = scale_i; // RL16
    end else if (hit) begin
      cnt_d = scale_i; // RL14 RL15
      div_d = ~div_q; // RL14
    end else if (tick_i) begin
      cnt_d = cnt_q - `PWMSD_CNT_ONE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `PWMSD_CNT_ZERO;
      div_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      div_q <= div_d;
    end
  end

  assign stick_o = hit & div_q;

  property p_scl_reload;
    @(posedge clk_i) disable iff (rst_i)
    load_i |=> cnt_q == $past(scale_i);
  endproperty
  a_scl_reload: assert property (p_scl_reload) else $error("scale write did not reload"); // RL16

  property p_scl_wrap;
    @(posedge clk_i) disable iff (rst_i)
    (hit && !load_i) |=> (cnt_q == $past(scale_i)) && (div_q != $past(div_q));
  endproperty
  a_scl_wrap: assert property (p_scl_wrap) else $error("scale counter did not reload at one"); // RL14
endmodule // pwmsd_scaler

//--- logic/pwmsd_channel.sv
`include "pwmsd_defs.svh"
module pwmsd_channel (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          tick_i,
  input  wire logic                          cnt_wr_i,
  input  wire pwmsd_pkg::pwmsd_chan_cfg_type cfg_i,
  output pwmsd_pkg::pwmsd_chan_stat_type     stat_o
);
  import pwmsd_pkg::*;

  logic [7:0] cnt_q, cnt_d, per_q, per_d, dty_q, dty_d, nxt;
  logic       ff_q, ff_d, wrap;

  // ----------------------------------------
  // Left-aligned up counter with buffered period and duty
  // ----------------------------------------
  assign nxt  = cnt_q + `PWMSD_CNT_ONE;
  assign wrap = cfg_i.en & tick_i & (nxt == per_q);

  always_comb begin
    cnt_d = cnt_q;
    per_d = per_q;
    dty_d = dty_q;
    ff_d  = ff_q;
    if (!cfg_i.en) begin
      per_d = cfg_i.per;
      dty_d = cfg_i.dty;
    end
    if (cnt_wr_i || wrap) begin
      cnt_d = `PWMSD_CNT_ZERO; // RL21
      per_d = cfg_i.per;
      dty_d = cfg_i.dty;
      ff_d  = (cfg_i.dty == `PWMSD_CNT_ZERO);
    end else if (cfg_i.en && tick_i) begin // RL22
      cnt_d = nxt;
      ff_d  = ff_q | (nxt == dty_q); // RL18
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= `PWMSD_CNT_ZERO;
      per_q <= `PWMSD_PER_RST;
      dty_q <= `PWMSD_DTY_RST;
      ff_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      per_q <= per_d;
      dty_q <= dty_d;
      ff_q  <= ff_d;
    end
  end

  // Polarity one starts high and drops at the duty match
  assign stat_o.out  = cfg_i.pol ? ~ff_q : ff_q; // RL19 RL20
  assign stat_o.cnt  = cnt_q;
  assign stat_o.wrap = wrap | cnt_wr_i;

  property p_ch_hold;
    @(posedge clk_i) disable iff (rst_i)
    (!cfg_i.en && !cnt_wr_i) |=> cnt_q == $past(cnt_q);
  endproperty
  a_ch_hold: assert property (p_ch_hold) else $error("disabled counter moved"); // RL22

  property p_ch_wrap;
    @(posedge clk_i) disable iff (rst_i)
    wrap |=> (cnt_q == `PWMSD_CNT_ZERO) && (per_q == $past(cfg_i.per));
  endproperty
  a_ch_wrap: assert property (p_ch_wrap) else $error("period match did not restart"); // RL21
endmodule // pwmsd_channel

//--- logic/pwmsd_top.sv
// Behaviour
// RL1 - Shutdown input held active two clocks
// RL2 - Flag sets on every shutdown input edge (code flags edges only while the shutdown enable bit is set)
// RL3 - Interrupt when flag and enable set
// RL4 - Restart only when input inactive, at zero
// RL5 - Disabling shutdown resumes only at zero
// RL6 - Active shutdown forces enabled outputs to level
// RL7 - Status bit shows channel seven pin
// RL8 - Level bit selects active shutdown polarity
// RL9 - Enable makes pin input, gates controls
// RL10 - Prescaler stops in freeze when allowed
// RL11 - Prescaler stops when all channels off
// RL12 - Clocks A and B independently selected
// RL13 - Select n divides bus clock by 2^n
// RL14 - Scaler counts down, reloads, halves
// RL15 - Scale zero means 256
// RL16 - Scale write reloads counter at once
// RL17 - Channels pick prescaled or scaled clock
// RL18 - Eight-bit counter, period, duty per channel
// RL19 - Per-channel starting polarity
// RL20 - Polarity one starts high, drops at duty
// RL21 - Counter runs zero to period minus one
// RL22 - Disabled counter holds, resumes from hold
`include "pwmsd_defs.svh"
module pwmsd_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        freeze_i,
  input  wire logic        sd_pin_i,
  output logic      [7:0]  pwm_o,
  output logic      [7:0]  pwm_oe_o,
  output logic             irq_o
);
  import pwmsd_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic [6:0] pwmsd_mask(input logic [2:0] sel);
    pwmsd_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  function automatic logic pwmsd_hit(input logic [5:0] idx, input logic [5:0] base);
    logic [5:0] diff;
    diff = idx - base;
    pwmsd_hit = (idx >= base) && (diff < `PWMSD_NUM_CH);
  endfunction

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic [5:0]  idx;
  logic [2:0]  cnt_ch, per_ch, dty_ch;
  logic        wr;

  assign idx    = adr_i[7:2];
  assign cnt_ch = 3'(idx - `PWMSD_IDX_CNT0);
  assign per_ch = 3'(idx - `PWMSD_IDX_PER0);
  assign dty_ch = 3'(idx - `PWMSD_IDX_DTY0);
  // Write lands on the edge where the master sees ack
  assign wr     = cyc_i & stb_i & we_i & sel_i[0] & ack_q;
  assign ack_d  = cyc_i & stb_i & ~ack_q;

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [7:0] en_q, en_d, pol_q, pol_d, csel_q, csel_d, pre_q, pre_d;
  logic [7:0] ctl_q, ctl_d, scla_q, scla_d, sclb_q, sclb_d;
  logic [7:0] per_q [8];
  logic [7:0] per_d [8];
  logic [7:0] dty_q [8];
  logic [7:0] dty_d [8];
  logic       ie_q, ie_d, lvl_q, lvl_d, inl_q, inl_d, ena_q, ena_d;
  logic       sdn_wr, load_a, load_b;
  logic [7:0] cnt_wr;

  assign sdn_wr = wr & (idx == `PWMSD_IDX_SDN);
  assign load_a = wr & (idx == `PWMSD_IDX_SCLA);
  assign load_b = wr & (idx == `PWMSD_IDX_SCLB);

  always_comb begin
    en_d   = en_q;
    pol_d  = pol_q;
    csel_d = csel_q;
    pre_d  = pre_q;
    ctl_d  = ctl_q;
    scla_d = load_a ? dat_i[7:0] : scla_q;
    sclb_d = load_b ? dat_i[7:0] : sclb_q;
    per_d  = per_q;
    dty_d  = dty_q;
    cnt_wr = 8'h00;
    ie_d   = ie_q;
    lvl_d  = lvl_q;
    inl_d  = inl_q;
    ena_d  = ena_q;
    if (wr) begin
      unique case (idx)
        `PWMSD_IDX_ENABLE: en_d   = dat_i[7:0];
        `PWMSD_IDX_POL:    pol_d  = dat_i[7:0];
        `PWMSD_IDX_CLKSEL: csel_d = dat_i[7:0];
        `PWMSD_IDX_PRESC:  pre_d  = dat_i[7:0];
        `PWMSD_IDX_CTL:    ctl_d  = dat_i[7:0];
        `PWMSD_IDX_SDN: begin
          ie_d  = dat_i[`PWMSD_SDN_IE];
          lvl_d = dat_i[`PWMSD_SDN_LVL];
          inl_d = dat_i[`PWMSD_SDN_INL];
          ena_d = dat_i[`PWMSD_SDN_ENA];
        end
        default: begin
          if (pwmsd_hit(idx, `PWMSD_IDX_CNT0)) begin
            cnt_wr[cnt_ch] = 1'b1;
          end
          if (pwmsd_hit(idx, `PWMSD_IDX_PER0)) begin
            per_d[per_ch] = dat_i[7:0];
          end
          if (pwmsd_hit(idx, `PWMSD_IDX_DTY0)) begin
            dty_d[dty_ch] = dat_i[7:0];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= `PWMSD_REG_RST;
      pol_q  <= `PWMSD_REG_RST;
      csel_q <= `PWMSD_REG_RST;
      pre_q  <= `PWMSD_REG_RST;
      ctl_q  <= `PWMSD_REG_RST;
      scla_q <= `PWMSD_REG_RST;
      sclb_q <= `PWMSD_REG_RST;
      per_q  <= '{default: `PWMSD_PER_RST};
      dty_q  <= '{default: `PWMSD_DTY_RST};
      ie_q   <= 1'b0;
      lvl_q  <= 1'b0;
      inl_q  <= 1'b0;
      ena_q  <= 1'b0;
    end else begin
      en_q   <= en_d;
      pol_q  <= pol_d;
      csel_q <= csel_d;
      pre_q  <= pre_d;
      ctl_q  <= ctl_d;
      scla_q <= scla_d;
      sclb_q <= sclb_d;
      per_q  <= per_d;
      dty_q  <= dty_d;
      ie_q   <= ie_d;
      lvl_q  <= lvl_d;
      inl_q  <= inl_d;
      ena_q  <= ena_d;
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  logic [6:0] pre_cnt_q, pre_cnt_d, mask_a, mask_b;
  logic       run, tick_a, tick_b;

  // Stopping the counter also stops every clock downstream
  assign run = (|en_q) & ~(freeze_i & ctl_q[`PWMSD_CTL_FRZ]); // RL10 RL11
  assign mask_a = pwmsd_mask(pre_q[`PWMSD_PRE_A_LSB +: 3]); // RL12 RL13
  assign mask_b = pwmsd_mask(pre_q[`PWMSD_PRE_B_LSB +: 3]); // RL12 RL13
  assign tick_a = run & ((pre_cnt_q & mask_a) == mask_a);
  assign tick_b = run & ((pre_cnt_q & mask_b) == mask_b);
  assign pre_cnt_d = run ? pre_cnt_q + 7'h01 : pre_cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt_q <= 7'h00;
    end else begin
      pre_cnt_q <= pre_cnt_d;
    end
  end

  logic stick_a, stick_b;

  pwmsd_scaler u_scale_a (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick_a),
    .load_i  (load_a),
    .scale_i (scla_d),
    .stick_o (stick_a)
  );

  pwmsd_scaler u_scale_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (tick_b),
    .load_i  (load_b),
    .scale_i (sclb_d),
    .stick_o (stick_b)
  );

  // ----------------------------------------
  // Emergency shutdown
  // ----------------------------------------
  logic       pin_q, flag_q, flag_d, rel_q, rel_d, sd_act, sd_chg;
  logic [7:0] hold_q, hold_d, wraps;

  // Pin level is taken as synchronous, no filter on it
  assign sd_act = ena_q & (sd_pin_i == inl_q); // RL8 RL9
  assign sd_chg = ena_q & (sd_pin_i != pin_q);

  always_comb begin
    // A change in the clearing cycle still sets the flag
    flag_d = sd_chg | (flag_q & ~(sdn_wr & dat_i[`PWMSD_SDN_FLAG])); // RL2
    rel_d  = rel_q;
    if (sd_act || hold_q == 8'h00) begin
      rel_d = 1'b0;
    end
    if (sdn_wr && dat_i[`PWMSD_SDN_RSTRT] && ena_q && !sd_act) begin
      rel_d = 1'b1; // RL4
    end
    if (sdn_wr && !dat_i[`PWMSD_SDN_ENA]) begin
      rel_d = 1'b1; // RL5
    end
    for (int i = 0; i < 8; i++) begin
      hold_d[i] = sd_act | (hold_q[i] & ~(rel_q & wraps[i])); // RL4 RL5
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q  <= 1'b0;
      flag_q <= 1'b0;
      rel_q  <= 1'b0;
      hold_q <= 8'h00;
    end else begin
      pin_q  <= sd_pin_i;
      flag_q <= flag_d;
      rel_q  <= rel_d;
      hold_q <= hold_d;
    end
  end

  assign irq_o = ena_q & ie_q & flag_q; // RL3

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  pwmsd_chan_stat_type stat [8];

  for (genvar g = 0; g < 8; g++) begin : g_ch
    pwmsd_chan_cfg_type cfg;
    logic               tick;
    // Bit one of the index picks the A or B family
    if ((g / 2) % 2 == 0) begin : g_a
      assign tick = csel_q[g] ? stick_a : tick_a; // RL17
    end else begin : g_b
      assign tick = csel_q[g] ? stick_b : tick_b; // RL17
    end
    assign cfg = '{en: en_q[g], pol: pol_q[g], per: per_q[g], dty: dty_q[g]};
    assign wraps[g] = stat[g].wrap; // RL4 RL5

    pwmsd_channel u_ch (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .tick_i   (tick),
      .cnt_wr_i (cnt_wr[g]),
      .cfg_i    (cfg),
      .stat_o   (stat[g])
    );

    // Force acts in the same cycle the pin goes active
    assign pwm_o[g] = en_q[g] & ((sd_act | hold_q[g]) ? lvl_q : stat[g].out); // RL6
    if (g == `PWMSD_SD_CH) begin : g_in
      assign pwm_oe_o[g] = en_q[g] & ~ena_q; // RL9
    end else begin : g_out
      assign pwm_oe_o[g] = en_q[g];
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    dat_d = 32'h0000_0000;
    unique case (idx)
      `PWMSD_IDX_ENABLE: dat_d[7:0] = en_q;
      `PWMSD_IDX_POL:    dat_d[7:0] = pol_q;
      `PWMSD_IDX_CLKSEL: dat_d[7:0] = csel_q;
      `PWMSD_IDX_PRESC:  dat_d[7:0] = pre_q;
      `PWMSD_IDX_CTL:    dat_d[7:0] = ctl_q;
      `PWMSD_IDX_SCLA:   dat_d[7:0] = scla_q;
      `PWMSD_IDX_SCLB:   dat_d[7:0] = sclb_q;
      `PWMSD_IDX_SDN: begin
        dat_d[`PWMSD_SDN_FLAG] = flag_q;
        dat_d[`PWMSD_SDN_IE]   = ie_q;
        dat_d[`PWMSD_SDN_LVL]  = lvl_q;
        dat_d[`PWMSD_SDN_PIN]  = sd_pin_i; // RL7
        dat_d[`PWMSD_SDN_INL]  = inl_q;
        dat_d[`PWMSD_SDN_ENA]  = ena_q;
      end
      default: begin
        if (pwmsd_hit(idx, `PWMSD_IDX_CNT0)) begin
          dat_d[7:0] = stat[cnt_ch].cnt;
        end
        if (pwmsd_hit(idx, `PWMSD_IDX_PER0)) begin
          dat_d[7:0] = per_q[per_ch];
        end
        if (pwmsd_hit(idx, `PWMSD_IDX_DTY0)) begin
          dat_d[7:0] = dty_q[dty_ch];
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= ack_d ? dat_d : dat_q;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_flag_set;
    @(posedge clk_i) disable iff (rst_i)
    (ena_q && sd_pin_i != $past(sd_pin_i)) ##1 1'b1 |-> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("pin edge not flagged"); // RL2

  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    irq_o == (flag_q && ie_q && ena_q);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch"); // RL3

  property p_rstrt_read;
    @(posedge clk_i) disable iff (rst_i)
    (ack_d && idx == `PWMSD_IDX_SDN) |=> !dat_o[`PWMSD_SDN_RSTRT];
  endproperty
  a_rstrt_read: assert property (p_rstrt_read) else $error("restart bit read as one"); // RL4

  property p_force;
    @(posedge clk_i) disable iff (rst_i)
    (ena_q && sd_pin_i == inl_q) |-> ((pwm_o & en_q) == (en_q & {8{lvl_q}}));
  endproperty
  a_force: assert property (p_force) else $error("outputs not forced"); // RL6

  property p_hold_zero;
    @(posedge clk_i) disable iff (rst_i)
    (hold_q[0] && !sd_act && !(rel_q && wraps[0])) |=> hold_q[0];
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("release before zero"); // RL4

  property p_pin_in;
    @(posedge clk_i) disable iff (rst_i)
    ena_q |-> !pwm_oe_o[`PWMSD_SD_CH];
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("shutdown pin driven"); // RL9

  property p_freeze;
    @(posedge clk_i) disable iff (rst_i)
    ((freeze_i && ctl_q[`PWMSD_CTL_FRZ]) || en_q == 8'h00) |=> $stable(pre_cnt_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("prescaler ran while gated"); // RL10

  property p_div1;
    @(posedge clk_i) disable iff (rst_i)
    (run && pre_q[`PWMSD_PRE_A_LSB +: 3] == 3'h0) |-> tick_a;
  endproperty
  a_div1: assert property (p_div1) else $error("select zero not full rate"); // RL13
endmodule // pwmsd_top

//--- bench/pwmsd_pin_model.sv
// ----------------------------------------
// Far-side source of the shutdown input
// ----------------------------------------
module pwmsd_pin_model (
  input  wire logic       clk_i,
  input  wire logic       level_i,
  input  wire logic [3:0] lag_i,
  output logic            pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_q;
  logic [1:0] held_q;

  initial begin
    pin_o  = 1'b0;
    wait_q = 4'h0;
    held_q = 2'h0;
  end

  // Lag lets the source answer promptly or slowly
  always @(posedge clk_i) begin
    if (held_q != 2'h3) held_q <= held_q + 2'h1;
    if (level_i == pin_o) begin
      wait_q <= 4'h0;
    end else if (wait_q < lag_i) begin
      wait_q <= wait_q + 4'h1;
    end else if (held_q >= 2'h2) begin
      pin_o  <= level_i;
      held_q <= 2'h0;
      wait_q <= 4'h0;
    end
  end
endmodule // pwmsd_pin_model

//--- bench/tb_top.sv
`include "pwmsd_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pwmsd_pkg::*;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, freeze_i, sd_pin_i, irq_o;
  logic        pin_req, meas_stb;
  logic [3:0]  pin_lag, sel_i;
  logic [7:0]  adr_i, pwm_o, pwm_oe_o, ch, per, dty, na, nb, s;
  logic [31:0] dat_i, dat_o, meas_v, e;
  logic [31:0] exp_q[$];
  logic        pol, csel;
  int          n_fail, check_count, cyc_n, plen, hi_exp;

  pwmsd_top uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .freeze_i(freeze_i), .sd_pin_i(sd_pin_i), .pwm_o(pwm_o), .pwm_oe_o(pwm_oe_o),
    .irq_o(irq_o));
  pwmsd_pin_model pin_m (.clk_i(clk_i), .level_i(pin_req), .lag_i(pin_lag),
    .pin_o(sd_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Request held until ack is sampled high
  task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d,
                     input logic sl);
    int t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, d};
    sel_i <= {3'b000, sl};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 100);
    if (t >= 100) begin
      $display("MISMATCH %0t no ack", $time);
      n_fail++;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // Extra edge so callers see the written state settled
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d, 1'b1);
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] x);
    exp_q.push_back({24'h0, x});
    bus(idx, 1'b0, 8'h00, 1'b1);
  endtask

  task automatic show(input logic [31:0] v, input logic [31:0] x);
    exp_q.push_back(x);
    meas_v   <= v;
    meas_stb <= 1'b1;
    @(posedge clk_i);
    meas_stb <= 1'b0;
  endtask

  // High-time count over whole periods is phase independent
  task automatic run(input int c, input int warm, input int win, input int x);
    int hi;
    hi = 0;
    repeat (warm) @(posedge clk_i);
    repeat (win) begin
      @(posedge clk_i);
      hi += int'(pwm_o[c]);
    end
    show(32'(hi), 32'(x));
  endtask

  task automatic pin(input logic v);
    int t;
    pin_req <= v;
    pin_lag <= 4'($urandom_range(3));
    t = 0;
    while (sd_pin_i !== v && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    if (t >= 20) begin
      $display("MISMATCH %0t pin stuck", $time);
      n_fail++;
    end
    repeat (2) @(posedge clk_i);
  endtask

  task automatic cfg();
    wr(`PWMSD_IDX_ENABLE, 8'h00);
    wr(`PWMSD_IDX_POL, 8'(pol) << ch);
    wr(`PWMSD_IDX_CLKSEL, 8'(csel) << ch);
    wr(`PWMSD_IDX_PRESC, {1'b0, nb[2:0], 1'b0, na[2:0]});
    wr(`PWMSD_IDX_SCLA, s);
    wr(`PWMSD_IDX_SCLB, s);
    wr(`PWMSD_IDX_PER0 + ch[5:0], per);
    wr(`PWMSD_IDX_DTY0 + ch[5:0], dty);
    wr(`PWMSD_IDX_CNT0 + ch[5:0], 8'h00);
    wr(`PWMSD_IDX_ENABLE, 8'h01 << ch);
  endtask

  // ----------------------------------------
  // Checking and timeout
  // ----------------------------------------
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 40000) begin
      n_fail++;
      stop_test();
    end
    if ((ack_o === 1'b1 && cyc_i && !we_i) || meas_stb) begin
      e = exp_q.pop_front();
      if (meas_stb) `CHK(meas_v, e)
      else `CHK(dat_o, e)
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {cyc_i, stb_i, we_i, freeze_i, pin_req, meas_stb} = 6'h00;
    {adr_i, sel_i, dat_i, pin_lag, meas_v} = '0;
    {n_fail, check_count, cyc_n} = '0;
    rst_i = 1'b1;
    void'($urandom(41964));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PWMSD_IDX_SDN, 8'h00);
    rd(`PWMSD_IDX_DTY0, 8'hff);
    rd(`PWMSD_IDX_PER0, 8'h00);
    bus(`PWMSD_IDX_POL, 1'b1, 8'hff, 1'b0);
    rd(`PWMSD_IDX_POL, 8'h00);
    wr(6'h3f, 8'h5a);
    rd(6'h3f, 8'h00);
    // Random clock trees; first pass takes scale zero
    for (int i = 0; i < 6; i++) begin
      ch = 8'($urandom_range(7));
      per = 8'($urandom_range(6, 2));
      dty = 8'($urandom_range(int'(per) - 1, 1));
      pol = 1'($urandom_range(1));
      na = 8'($urandom_range(2));
      nb = 8'($urandom_range(2));
      csel = 1'($urandom_range(1));
      s = 8'($urandom_range(3, 1));
      if (i == 0) begin
        {csel, s, per, dty, na, nb} = {1'b1, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
      end
      cfg();
      plen = int'(per) << ((ch[1] == 1'b0) ? na : nb);
      if (csel) plen = plen * 2 * ((s == 8'h00) ? 256 : int'(s));
      hi_exp = 2 * (pol ? int'(dty) : int'(per - dty)) * plen / int'(per);
      run(int'(ch), 2 * plen, 2 * plen, hi_exp);
    end
    {ch, per, dty, pol, csel, na, nb, s} = {8'h00, 8'h04, 8'h02, 1'b1, 1'b0, 24'h000001};
    cfg();
    run(0, 8, 40, 20);
    wr(`PWMSD_IDX_ENABLE, 8'h81);
    show({24'h0, pwm_oe_o}, 32'h81);
    wr(`PWMSD_IDX_SDN, 8'h43);
    show({31'h0, pwm_oe_o[7]}, 32'h0);
    rd(`PWMSD_IDX_SDN, 8'h43);
    pin(1'b1);
    show({31'h0, irq_o}, 32'h1);
    run(0, 0, 40, 0);
    rd(`PWMSD_IDX_SDN, 8'hc7);
    wr(`PWMSD_IDX_SDN, 8'h63);
    run(0, 8, 40, 0);
    rd(`PWMSD_IDX_SDN, 8'hc7);
    wr(`PWMSD_IDX_SDN, 8'hc3);
    show({31'h0, irq_o}, 32'h0);
    rd(`PWMSD_IDX_SDN, 8'h47);
    pin(1'b0);
    rd(`PWMSD_IDX_SDN, 8'hc3);
    run(0, 8, 40, 0);
    wr(`PWMSD_IDX_SDN, 8'he3);
    run(0, 8, 40, 20);
    rd(`PWMSD_IDX_SDN, 8'h43);
    wr(`PWMSD_IDX_SDN, 8'h11);
    run(0, 2, 40, 40);
    pin(1'b1);
    show({31'h0, irq_o}, 32'h0);
    rd(`PWMSD_IDX_SDN, 8'h95);
    wr(`PWMSD_IDX_SDN, 8'h00);
    run(0, 8, 40, 20);
    // Freeze gate must hold a freshly cleared counter
    wr(`PWMSD_IDX_CTL, 8'h04);
    freeze_i <= 1'b1;
    wr(`PWMSD_IDX_CNT0, 8'h00);
    repeat (10) @(posedge clk_i);
    rd(`PWMSD_IDX_CNT0, 8'h00);
    freeze_i <= 1'b0;
    run(0, 8, 40, 20);
    stop_test();
  end
endmodule // tb_top
